/* File: flash_self_program_defines.svh */
`ifndef FLASH_SELF_PROGRAM_DEFINES_SVH
`define FLASH_SELF_PROGRAM_DEFINES_SVH

// control register field positions
`define FOC_START_BIT      4'd15
`define FOC_ENABLE_BIT     4'd14
`define FOC_ERROR_BIT      4'd13
`define FOC_ERASE_BIT      4'd6
`define FOC_RESET          16'h0000
`define FOC_WRITE_MASK     16'h404f

// unlock key values
`define KEY_FIRST          8'h55
`define KEY_SECOND         8'haa

// operation codes
`define OP_BULK_ERASE      4'hf
`define OP_WORD_PROGRAM    4'h3
`define OP_PAGE_ERASE      4'h2
`define OP_ROW_PROGRAM     4'h1

// array geometry
`define ROW_WORDS          64
`define ROW_BYTES          192
`define BLOCK_WORDS        512
`define BLOCK_BYTES        1536
`define ROWS_PER_BLOCK     8
`define LATCH_ERASED       24'hffffff

// table write latency in clock cycles
`define TABLE_WRITE_CYCLES 2

// self-timed operation lengths
`define CLK_PERIOD_NS      5
`define PROG_TIME_NS       1000
`define ERASE_TIME_NS      2000
`define PROG_CYCLES        (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_CYCLES       (`ERASE_TIME_NS / `CLK_PERIOD_NS)

`endif

/* File: flash_self_program_pkg.sv */
package flash_self_program_pkg;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_ROW,
    OP_WORD,
    OP_PAGE_ERASE,
    OP_BULK
  } op_kind_t;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_GOT_FIRST,
    KEY_ARMED
  } key_state_t;

  typedef enum logic [1:0] {
    ENG_IDLE,
    ENG_BUSY,
    ENG_DONE
  } eng_state_t;

endpackage : flash_self_program_pkg

/* File: latch_if.sv */
`timescale 1ns/1ps
// holding latch write port between controller and latch array
interface latch_if;
  logic        wr_low;
  logic        wr_high;
  logic [1:0]  byte_en;
  logic [5:0]  index;
  logic [15:0] wdata;
  logic [5:0]  rindex;
  logic [23:0] rdata;
  modport ctrl  (output wr_low, wr_high, byte_en, index, wdata, rindex,
                 input rdata);
  modport latch (input wr_low, wr_high, byte_en, index, wdata, rindex,
                 output rdata);
endinterface : latch_if

/* File: holding_latches.sv */
`timescale 1ns/1ps
`include "flash_self_program_defines.svh"

module holding_latches #(
  parameter int WORDS = `ROW_WORDS
) (
  // clock
  input wire logic mclk,
  // write and read port
  latch_if.latch   lp
);

  // contents are unknown at power up, software fills them
  logic [23:0] mem [WORDS];

  // latest load of a location replaces earlier ones, any order
  always_ff @(posedge mclk) begin
    if (lp.wr_low) begin
      if (lp.byte_en[0]) mem[lp.index][7:0]  <= lp.wdata[7:0];
      if (lp.byte_en[1]) mem[lp.index][15:8] <= lp.wdata[15:8];
    end
    if (lp.wr_high && lp.byte_en[0]) begin
      mem[lp.index][23:16] <= lp.wdata[7:0];
    end
  end

  assign lp.rdata = mem[lp.rindex];

endmodule : holding_latches

/* File: flash_self_program_control.sv */
`timescale 1ns/1ps
`include "flash_self_program_defines.svh"
// How it works
// - rows of 64 words, erase eight-row blocks
// - address is table page plus effective address
// - low table ops touch bits 15..0
// - high table ops touch bits 23..16
// - rows and blocks aligned from address zero
// - table writes fill latches, array untouched
// - program works with any latch count
// - latches take any order, last wins
// - table write takes two cycles
// - key register write-only, guards start
// - start bit launches, hardware clears when done
// - enable bit gates program and erase
// - error flag on bad start or abort
// - bit 6 selects erase or program
// - opcode decode, wrong erase select no-op
// - undefined opcodes do nothing
// - bulk erase only in serial mode
// - control bits reset only at power-on
// - core stalls while operation runs

module flash_self_program_control #(
  parameter int PROG_CYCLES  = `PROG_CYCLES,
  parameter int ERASE_CYCLES = `ERASE_CYCLES
) (
  // clock and resets
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        por,
  // operating mode
  input  wire logic        serial_prog_mode,
  // core register access
  input  wire logic        ctl_wr,
  input  wire logic [15:0] ctl_wdata,
  output logic      [15:0] ctl_rdata,
  input  wire logic        key_wr,
  input  wire logic [7:0]  key_wdata,
  input  wire logic        page_wr,
  input  wire logic [7:0]  page_wdata,
  output logic      [7:0]  table_page,
  // core table accesses
  input  wire logic        table_write,
  input  wire logic        table_write_high,
  input  wire logic        table_read,
  input  wire logic        table_read_high,
  input  wire logic        byte_mode,
  input  wire logic [15:0] effective_address,
  input  wire logic [15:0] table_wdata,
  output logic      [15:0] table_rdata,
  output logic             table_done,
  // read data from array at the formed address
  output logic      [23:0] flash_addr,
  input  wire logic [23:0] flash_rdata,
  // array operation
  output logic             flash_op_start,
  output flash_self_program_pkg::op_kind_t flash_op_kind,
  output logic      [23:0] flash_op_base,
  output logic      [23:0] latch_data,
  output logic      [5:0]  latch_index,
  input  wire logic        flash_abort,
  // core stall
  output logic             core_stall
);

  // all control state in one record
  typedef struct packed {
    logic        start;
    logic        enable;
    logic        error;
    logic        erase_sel;
    logic [3:0]  op_code;
    logic [7:0]  page;
    flash_self_program_pkg::key_state_t key;
    flash_self_program_pkg::eng_state_t eng;
    flash_self_program_pkg::op_kind_t   kind;
    logic [23:0] base;
    logic [15:0] count;
    logic [5:0]  prog_idx;
    logic        tw_busy;
    logic        tw_high;
    logic [15:0] rdata;
    logic        done;
    logic        launch;
  } state_t;

  state_t s_q;
  state_t s_d;

  latch_if lp ();

  // opcode plus erase select into an operation
  function automatic flash_self_program_pkg::op_kind_t decode_op(
    input logic [3:0] code,
    input logic       erase,
    input logic       serial
  );
    flash_self_program_pkg::op_kind_t k;
    k = flash_self_program_pkg::OP_NONE;
    unique case (code)
      `OP_BULK_ERASE: begin
        if (erase && serial) k = flash_self_program_pkg::OP_BULK;
      end
      `OP_WORD_PROGRAM: begin
        if (!erase) k = flash_self_program_pkg::OP_WORD;
      end
      `OP_PAGE_ERASE: begin
        if (erase) k = flash_self_program_pkg::OP_PAGE_ERASE;
      end
      `OP_ROW_PROGRAM: begin
        if (!erase) k = flash_self_program_pkg::OP_ROW;
      end
      default: k = flash_self_program_pkg::OP_NONE;
    endcase
    return k;
  endfunction : decode_op

  // align the target to its row or erase block
  function automatic logic [23:0] align_base(
    input logic [23:0]                      addr,
    input flash_self_program_pkg::op_kind_t kind
  );
    logic [23:0] word;
    logic [23:0] unit;
    word = {1'b0, addr[23:1]};
    unit = 24'h000001;
    if (kind == flash_self_program_pkg::OP_ROW) begin
      unit = 24'(`ROW_WORDS);
    end else if (kind == flash_self_program_pkg::OP_PAGE_ERASE) begin
      unit = 24'(`BLOCK_WORDS);
    end
    // multiply back to program-space address units
    return 24'((word - (word % unit)) << 1);
  endfunction : align_base

  logic [23:0] target;
  logic        ctl_start_req;
  logic        ok;
  flash_self_program_pkg::op_kind_t req_kind;

  // 24-bit address from page and effective address
  assign target = {s_q.page, effective_address};
  assign flash_addr = target;
  assign req_kind = decode_op(ctl_wdata[3:0], ctl_wdata[`FOC_ERASE_BIT],
                              serial_prog_mode);
  assign ctl_start_req = ctl_wr && ctl_wdata[`FOC_START_BIT] && !s_q.start;
  assign ok = (s_q.key == flash_self_program_pkg::KEY_ARMED) &&
              ctl_wdata[`FOC_ENABLE_BIT];

  // latch port: loads go to the buffer only
  assign lp.wr_low  = table_write && !s_q.tw_busy;
  assign lp.wr_high = table_write_high && !s_q.tw_busy;
  assign lp.index   = effective_address[6:1];
  assign lp.byte_en = byte_mode ?
                      (effective_address[0] ? 2'b10 : 2'b01) : 2'b11;
  assign lp.wdata   = (byte_mode && effective_address[0]) ?
                      {table_wdata[7:0], table_wdata[7:0]} : table_wdata;
  assign lp.rindex  = s_q.prog_idx;

  holding_latches #(
    .WORDS (`ROW_WORDS)
  ) u_latches (
    .mclk (mclk),
    .lp   (lp)
  );

  always_comb begin
    s_d = s_q;
    s_d.done   = 1'b0;
    s_d.launch = 1'b0;

    // table page register
    if (page_wr) s_d.page = page_wdata;

    // two-cycle table write, finishes in second cycle
    if (s_q.tw_busy) begin
      s_d.tw_busy = 1'b0;
      s_d.done    = 1'b1;
    end else if (table_write || table_write_high) begin
      s_d.tw_busy = 1'b1;
    end

    // table reads of the low word or high byte
    if (table_read) begin
      s_d.rdata = (byte_mode && effective_address[0]) ?
                  {8'h00, flash_rdata[15:8]} :
                  (byte_mode ? {8'h00, flash_rdata[7:0]}
                             : flash_rdata[15:0]);
      s_d.done  = 1'b1;
    end else if (table_read_high) begin
      s_d.rdata = {8'h00, flash_rdata[23:16]};
      s_d.done  = 1'b1;
    end

    // key sequence; any other key access disarms
    if (key_wr) begin
      if (key_wdata == `KEY_FIRST) begin
        s_d.key = flash_self_program_pkg::KEY_GOT_FIRST;
      end else if (key_wdata == `KEY_SECOND &&
                   s_q.key == flash_self_program_pkg::KEY_GOT_FIRST) begin
        s_d.key = flash_self_program_pkg::KEY_ARMED;
      end else begin
        s_d.key = flash_self_program_pkg::KEY_IDLE;
      end
    end

    // control register writes while idle
    if (ctl_wr && !s_q.start) begin
      s_d.enable    = ctl_wdata[`FOC_ENABLE_BIT];
      s_d.erase_sel = ctl_wdata[`FOC_ERASE_BIT];
      s_d.op_code   = ctl_wdata[3:0];
      if (ctl_start_req) begin
        s_d.key = flash_self_program_pkg::KEY_IDLE; // keys are single use
        if (ok && req_kind != flash_self_program_pkg::OP_NONE) begin
          s_d.start  = 1'b1;
          s_d.error  = 1'b0;
          s_d.eng    = flash_self_program_pkg::ENG_BUSY;
          s_d.kind   = req_kind;
          s_d.base   = align_base(target, req_kind);
          s_d.count  = 16'((req_kind == flash_self_program_pkg::OP_PAGE_ERASE
                       || req_kind == flash_self_program_pkg::OP_BULK) ?
                       ERASE_CYCLES : PROG_CYCLES);
          s_d.prog_idx = (req_kind == flash_self_program_pkg::OP_WORD) ?
                         effective_address[6:1] : 6'h00;
          s_d.launch = 1'b1;
        end else if (!ok) begin
          s_d.error = 1'b1;
        end
      end
    end

    // self-timed engine
    unique case (s_q.eng)
      flash_self_program_pkg::ENG_IDLE: begin
      end
      flash_self_program_pkg::ENG_BUSY: begin
        if (flash_abort) begin
          s_d.error = 1'b1;
          s_d.eng   = flash_self_program_pkg::ENG_DONE;
        end else if (s_q.count <= 16'h0001) begin
          s_d.eng = flash_self_program_pkg::ENG_DONE;
        end else begin
          s_d.count = s_q.count - 16'h0001;
          // row program walks every latch whatever was loaded
          if (s_q.kind == flash_self_program_pkg::OP_ROW) begin
            s_d.prog_idx = s_q.prog_idx + 6'h01;
          end
        end
      end
      flash_self_program_pkg::ENG_DONE: begin
        s_d.start = 1'b0;
        s_d.eng   = flash_self_program_pkg::ENG_IDLE;
      end
    endcase
  end

  // power-on reset clears control bits, other reset spares them
  always_ff @(posedge mclk) begin
    if (por) begin
      s_q <= '0;
    end else if (rst) begin
      s_q.key     <= flash_self_program_pkg::KEY_IDLE;
      s_q.page    <= 8'h00;
      s_q.tw_busy <= 1'b0;
      s_q.done    <= 1'b0;
      s_q.launch  <= 1'b0;
      s_q.rdata   <= 16'h0000;
      s_q.start   <= s_d.start;
      s_q.enable  <= s_d.enable;
      s_q.error   <= s_d.error;
      s_q.erase_sel <= s_d.erase_sel;
      s_q.op_code <= s_d.op_code;
      s_q.eng     <= s_d.eng;
      s_q.kind    <= s_d.kind;
      s_q.base    <= s_d.base;
      s_q.count   <= s_d.count;
      s_q.prog_idx <= s_d.prog_idx;
    end else begin
      s_q <= s_d;
    end
  end

  // register views and outputs
  assign ctl_rdata = {s_q.start, s_q.enable, s_q.error, 6'h00,
                      s_q.erase_sel, 2'b00, s_q.op_code};
  assign table_page     = s_q.page;
  assign table_rdata    = s_q.rdata;
  assign table_done     = s_q.done;
  assign flash_op_start = s_q.launch;
  assign flash_op_kind  = s_q.kind;
  assign flash_op_base  = s_q.base;
  assign latch_index    = s_q.prog_idx;
  assign latch_data     = lp.rdata;
  // stall the core for the whole operation
  assign core_stall     = s_q.start;

endmodule : flash_self_program_control

/* File: flash_self_program_control_props.sv */
`timescale 1ns/1ps
module flash_self_program_control_props #(
  parameter int PROG_CYCLES  = 4,
  parameter int ERASE_CYCLES = 4
) (
  // clock and resets
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        por,
  // control access
  input wire logic        serial_prog_mode,
  input wire logic        ctl_wr,
  input wire logic [15:0] ctl_wdata,
  input wire logic [15:0] ctl_rdata,
  // table and array side
  input wire logic        table_write,
  input wire logic        table_write_high,
  input wire logic        table_done,
  input wire logic        flash_op_start,
  input wire flash_self_program_pkg::op_kind_t flash_op_kind,
  input wire logic [23:0] flash_op_base,
  input wire logic        core_stall
);
  logic [15:0] run_q;
  logic        idle_wr;
  // stalled cycles so far; cleared by por or a stall-free cycle, not by rst, as the run outlives rst
  always_ff @(posedge mclk) begin
    run_q <= (por || !core_stall) ? 16'h0000 : run_q + 16'h0001;
  end
  assign idle_wr = ctl_wr && !ctl_rdata[15];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || por);
  chk_stall_tracks: assert property (
    core_stall == ctl_rdata[15]) else $error("stall off start bit");
  chk_run_bound: assert property (
    core_stall |-> run_q <= ERASE_CYCLES) else $error("op overran");
  chk_needs_enable: assert property (
    idle_wr && !ctl_wdata[14] |=> !flash_op_start && !core_stall)
    else $error("op while disabled");
  chk_wrong_select: assert property (
    idle_wr && ctl_wdata[6] && ctl_wdata[3:0] inside {4'h1, 4'h3}
    |=> !flash_op_start) else $error("program ran as erase");
  chk_bad_code: assert property (
    idle_wr && !(ctl_wdata[3:0] inside {4'h1, 4'h2, 4'h3, 4'hf})
    |=> !flash_op_start) else $error("bad code ran");
  chk_bulk_mode: assert property (
    flash_op_start && flash_op_kind == flash_self_program_pkg::OP_BULK
    |-> $past(serial_prog_mode)) else $error("bulk outside serial");
  chk_write_done: assert property (
    table_write || table_write_high |=> !table_done ##1 table_done)
    else $error("table write length");
  chk_row_base: assert property (
    flash_op_start && flash_op_kind == flash_self_program_pkg::OP_ROW
    |-> flash_op_base[6:0] == 7'h00) else $error("row unaligned");
  chk_ctl_keep: assert property (
    @(posedge mclk) disable iff (por) rst && !ctl_wr |=>
    ctl_rdata[14] == $past(ctl_rdata[14]) &&
    ctl_rdata[6:0] == $past(ctl_rdata[6:0])) else $error("ctl lost");
  // main scenarios
  cover property (flash_op_start);
  cover property (flash_op_start &&
    flash_op_kind == flash_self_program_pkg::OP_BULK);
  cover property ($fell(core_stall) && ctl_rdata[13]);
endmodule : flash_self_program_control_props

bind flash_self_program_control flash_self_program_control_props #(
  .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)
) chk_u (
  .mclk, .rst, .por, .serial_prog_mode, .ctl_wr, .ctl_wdata, .ctl_rdata,
  .table_write, .table_write_high, .table_done, .flash_op_start,
  .flash_op_kind, .flash_op_base, .core_stall
);

/* File: flash_array_model.sv */
`timescale 1ns/1ps
module flash_array_model (
  // array side
  input  wire logic        mclk,
  input  wire logic [23:0] flash_addr,
  input  wire logic        flash_op_start,
  output logic      [23:0] flash_rdata,
  output logic             flash_abort,
  // scenario control
  input  wire logic        abort_en
);
  logic [3:0] age_q;
  // data mixes page and offset so a wrong address reads wrong
  assign flash_rdata = {flash_addr[23:16] ^ flash_addr[7:0],
                        flash_addr[15:0] ^ 16'h0f0f};
  // age of current op, saturating so a stale abort never lingers
  always_ff @(posedge mclk) begin
    if (flash_op_start) age_q <= 4'h0;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  assign flash_abort = abort_en && age_q >= 4'h3 && age_q != 4'hf;
endmodule : flash_array_model

/* File: test_flash_self_program_control.sv */
`timescale 1ns/1ps
module test_flash_self_program_control;
  localparam int PC = 6;
  localparam int EC = 10;
  // stimulus
  logic        mclk, rst, por, serial_prog_mode, ctl_wr, key_wr, page_wr;
  logic        table_write, table_write_high, table_read, table_read_high;
  logic        byte_mode, abort_en;
  logic [15:0] ctl_wdata, effective_address, table_wdata;
  logic [7:0]  key_wdata, page_wdata;
  // responses
  logic [15:0] ctl_rdata, table_rdata;
  logic [7:0]  table_page;
  logic [23:0] flash_addr, flash_rdata, flash_op_base, latch_data, d;
  logic [5:0]  latch_index;
  logic        table_done, flash_op_start, flash_abort, core_stall;
  flash_self_program_pkg::op_kind_t flash_op_kind;
  int          num_errors, total_checks;

  flash_self_program_control #(
    .PROG_CYCLES(PC),
    .ERASE_CYCLES(EC)
  ) dut_u (
    .mclk, .rst, .por, .serial_prog_mode, .ctl_wr, .ctl_wdata, .ctl_rdata,
    .key_wr, .key_wdata, .page_wr, .page_wdata, .table_page, .table_write,
    .table_write_high, .table_read, .table_read_high, .byte_mode,
    .effective_address, .table_wdata, .table_rdata, .table_done,
    .flash_addr, .flash_rdata, .flash_op_start, .flash_op_kind,
    .flash_op_base, .latch_data, .latch_index, .flash_abort, .core_stall
  );
  flash_array_model model_u (
    .mclk, .flash_addr, .flash_op_start, .flash_rdata, .flash_abort,
    .abort_en
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [23:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [23:0] md(input logic [23:0] a);
    return {a[23:16] ^ a[7:0], a[15:0] ^ 16'h0f0f};
  endfunction : md

  // s: 0 control, 1 key, 2 page; one idle cycle between accesses
  task automatic wr(input logic [1:0] s, input logic [15:0] v);
    @(posedge mclk);
    {page_wr, key_wr, ctl_wr} <= 3'b001 << s;
    ctl_wdata <= v;
    key_wdata <= v[7:0];
    page_wdata <= v[7:0];
    @(posedge mclk);
    {page_wr, key_wr, ctl_wr} <= 3'b000;
  endtask : wr

  // s: 0 read low, 1 read high, 2 write low, 3 write high
  task automatic tbl(input logic [1:0] s, input logic bm,
                     input logic [15:0] ea, input logic [15:0] exp);
    int n;
    n = 0;
    @(posedge mclk);
    {table_write_high, table_write, table_read_high, table_read}
      <= 4'b0001 << s;
    byte_mode <= bm;
    effective_address <= ea;
    table_wdata <= exp;
    @(posedge mclk);
    {table_write_high, table_write, table_read_high, table_read} <= 4'h0;
    #1;
    check("addr", flash_addr, {8'h12, ea});
    while (table_done !== 1'b1 && n < 4) begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("done", n, s[1]);
    if (!s[1]) check("rdata", table_rdata[7:0], exp[7:0]);
    if (s == 2'd0 && !bm) check("rword", table_rdata, exp);
  endtask : tbl

  // k: 0 no keys, 1 proper keys, 2 first key only; len < 0 means aborted
  task automatic run(input logic [1:0] k, input logic [15:0] v,
                     input logic [23:0] kind, input int len, input logic err);
    int n;
    n = 0;
    wr(k == 2'd1 ? 2'd1 : 2'd3, k == 2'd2 ? 16'h00aa : 16'h0055);
    wr(k == 2'd1 ? 2'd1 : 2'd3, k == 2'd2 ? 16'h0055 : 16'h00aa);
    if (k == 2'd2) wr(2'd1, 16'h0055);
    wr(2'd0, v);
    #1;
    check("launch", flash_op_start, len != 0);
    if (len != 0) check("kind", flash_op_kind, kind);
    // polling gives the two slack slots software owes after a start
    while (core_stall === 1'b1 && n < 100) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (len >= 0) check("stall", n, len);
    if (len < 0) check("short", n < EC + 1, 1'b1);
    check("start", ctl_rdata[15], 1'b0);
    check("error", ctl_rdata[13], err);
  endtask : run

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // watchdog, far beyond the under two hundred cycles the run needs
  initial begin
    #40us;
    num_errors++;
    conclude();
  end

  initial begin
    {rst, por} = 2'b11;
    {serial_prog_mode, ctl_wr, key_wr, page_wr, abort_en} = 5'h00;
    {table_write, table_write_high, table_read, table_read_high} = 4'h0;
    {byte_mode, ctl_wdata, effective_address, table_wdata} = 49'h0;
    {key_wdata, page_wdata} = 16'h0000;
    num_errors = 0;
    total_checks = 0;
    repeat (10) @(posedge mclk);
    {rst, por} <= 2'b00;
    #1;
    check("reset view", ctl_rdata, 16'h0000);
    wr(2'd2, 16'h0012);
    #1;
    check("page", table_page, 8'h12);
    d = md(24'h123456);
    tbl(2'd0, 1'b0, 16'h3456, d[15:0]);
    tbl(2'd1, 1'b0, 16'h3456, {8'h00, d[23:16]});
    d = md(24'h123457);
    tbl(2'd0, 1'b1, 16'h3457, {8'h00, d[15:8]});
    tbl(2'd2, 1'b0, 16'h0086, 16'hffff);
    tbl(2'd3, 1'b0, 16'h0086, 16'h00ff);
    tbl(2'd2, 1'b0, 16'h0086, 16'h1234);
    // refused starts, then codes 1, 2 and 3 with both selections, 5 and f with erase
    run(2'd0, 16'hc001, 24'h0, 0, 1'b1);
    run(2'd2, 16'hc001, 24'h0, 0, 1'b1);
    run(2'd1, 16'h8001, 24'h0, 0, 1'b1);
    run(2'd1, 16'hc001, flash_self_program_pkg::OP_ROW, PC + 1, 1'b0);
    check("row base", flash_op_base, 24'h120080);
    run(2'd1, 16'hc003, flash_self_program_pkg::OP_WORD, PC + 1, 1'b0);
    check("word base", flash_op_base, 24'h120086);
    check("latch idx", latch_index, 24'h000003);
    check("latch word", latch_data, 24'hff1234);
    run(2'd1, 16'hc042, flash_self_program_pkg::OP_PAGE_ERASE, EC + 1,
        1'b0);
    check("erase base", flash_op_base, 24'h120000);
    run(2'd1, 16'hc041, 24'h0, 0, 1'b0);
    run(2'd1, 16'hc043, 24'h0, 0, 1'b0);
    run(2'd1, 16'hc002, 24'h0, 0, 1'b0);
    run(2'd1, 16'hc045, 24'h0, 0, 1'b0);
    run(2'd1, 16'hc04f, 24'h0, 0, 1'b0);
    @(posedge mclk);
    serial_prog_mode <= 1'b1;
    run(2'd1, 16'hc04f, flash_self_program_pkg::OP_BULK, EC + 1, 1'b0);
    @(posedge mclk);
    {serial_prog_mode, abort_en} <= 2'b01;
    run(2'd1, 16'hc042, flash_self_program_pkg::OP_PAGE_ERASE, -1, 1'b1);
    @(posedge mclk);
    abort_en <= 1'b0;
    wr(2'd0, 16'h4042);
    @(posedge mclk);
    rst <= 1'b1;
    @(posedge mclk);
    rst <= 1'b0;
    #1;
    check("kept", ctl_rdata, 16'h6042);
    @(posedge mclk);
    por <= 1'b1;
    @(posedge mclk);
    por <= 1'b0;
    #1;
    check("cleared", ctl_rdata, 16'h0000);
    conclude();
  end
endmodule : test_flash_self_program_control
